// *** hdl/bal_pkg.sv ***
// Purpose: shared constants for the byte add/and and bit-op datapath
// Assumes: 8-bit operands, opcodes as presented by the decoder
// Notes:   flag vector order is {c, z, s, v, d, h}
`default_nettype none
package bal_pkg;
  localparam int          BAL_W        = 8;
  localparam logic [7:0] OP_ADC_RR    = 8'h12;
  localparam logic [7:0] OP_ADC_IM    = 8'h16;
  localparam logic [7:0] OP_ADD_RR    = 8'h02;
  localparam logic [7:0] OP_ADD_IM    = 8'h06;
  localparam logic [7:0] OP_AND_RR    = 8'h52;
  localparam logic [7:0] OP_AND_IM    = 8'h56;
  localparam logic [7:0] OP_BAND      = 8'h67;
  localparam logic [7:0] OP_BIT_CMP   = 8'h17;
  localparam logic [7:0] OP_ADC_IR    = 8'h13;
  localparam logic [7:0] OP_ADD_IR    = 8'h03;
  localparam logic [7:0] OP_AND_IR    = 8'h53;
  // cycle counts
  localparam logic [3:0] CYC_SHORT    = 4'h4;
  localparam logic [3:0] CYC_LONG     = 4'h6;
  // byte lengths
  localparam logic [1:0] LEN_SHORT    = 2'h2;
  localparam logic [1:0] LEN_LONG     = 2'h3;
  // second-byte fields of bit instructions
  localparam int          BF_DIR       = 0;
  localparam int          BF_IDX_LO    = 1;
  localparam int          BF_IDX_HI    = 3;
  localparam int          BF_REG_LO    = 4;
  localparam int          BF_REG_HI    = 7;
  localparam int          MSB          = 7;
  localparam int          NIB_MSB      = 3;
  // flag positions
  localparam int          F_C          = 5;
  localparam int          F_Z          = 4;
  localparam int          F_S          = 3;
  localparam int          F_V          = 2;
  localparam int          F_D          = 1;
  localparam int          F_H          = 0;
  localparam logic [5:0] FLAGS_RST    = 6'h00;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  typedef enum logic [2:0] {
    BAL_IDLE = 3'b001,
    BAL_BUSY = 3'b010,
    BAL_DONE = 3'b100
  } bal_state_t;
endpackage
`default_nettype wire

// *** hdl/bal_bitop.sv ***
// Purpose: single-bit and/compare unit
// Assumes: operands already fetched; dir selects which side supplies bit 0
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module bal_bitop (
  // operands
  input  wire logic [7:0] dst_in,
  input  wire logic [7:0] src_in,
  input  wire logic [2:0] idx_in,
  input  wire logic       dir_in,
  input  wire logic       is_cmp_in,
  // results
  output logic [7:0]      res_out,
  output logic            zero_out
);
  logic rb;
  always_comb begin
    res_out  = dst_in;
    rb       = 1'b0;
    if (is_cmp_in) begin
      rb       = dst_in[0] ^ src_in[idx_in];
      zero_out = ~rb; // RQ13
    end else if (!dir_in) begin
      rb         = dst_in[0] & src_in[idx_in];
      res_out[0] = rb; // RQ10
      zero_out   = ~rb; // RQ12
    end else begin
      rb              = dst_in[idx_in] & src_in[0];
      res_out[idx_in] = rb; // RQ10
      zero_out        = ~rb; // RQ12
    end
  end
endmodule
`default_nettype wire

// *** hdl/bal_core.sv ***
// Purpose: byte add/adc/and and bit and/compare execution datapath
// Assumes: decoder presents opcode, second byte and fetched operands with start
// Notes:   result and flags are registered; done pulses when the cycle budget ends
// Notes on behaviour
// (RQ1) ADC stores dst+src+carry in dst; opcodes 12..16.
// (RQ2) ADD stores dst+src in dst, no carry in; opcodes 02..06.
// (RQ3) Both adds set carry on carry out of bit 7, else clear.
// (RQ4) Both adds set overflow when like-signed operands give opposite sign.
// (RQ5) Both adds set zero on zero result and sign on negative result.
// (RQ6) Both adds set half-carry from bit 3, always clear decimal-adjust.
// (RQ7) AND stores dst AND src in dst; opcodes 52..56.
// (RQ8) AND sets zero, copies bit 7 to sign, clears overflow, keeps C,D,H.
// (RQ9) Pair form 2 bytes/4 cycles; others 6 cycles, register forms 3 bytes.
// (RQ10) Bit AND (67) ANDs src bit b into dst bit 0, or src bit 0 into b.
// (RQ11) Second byte: 4-bit register, 3-bit index, direction bit in LSB.
// (RQ12) Bit AND sets zero on zero bit, clears sign, keeps carry.
// (RQ13) Bit compare (17) sets zero on match, clears sign, keeps carry, no write.
// (RQ14) Bit AND and bit compare are 3 bytes and 6 cycles.
// (RQ15) Undefined flags keep their previous value.
`timescale 1ns/1ps
`default_nettype none
module bal_core #(
  parameter int W = bal_pkg::BAL_W
) (
  // clock and control
  input  wire logic         sys_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         clk_en_in,
  // instruction
  input  wire logic         start_in,
  input  wire logic [7:0]   opcode_in,
  input  wire logic [7:0]   byte2_in,
  input  wire logic [W-1:0] dst_in,
  input  wire logic [W-1:0] src_in,
  // results
  output logic [W-1:0]      result_out,
  output logic              wr_dst_out,
  output logic [3:0]        wreg_addr_out,
  output logic [1:0]        inst_len_out,
  output logic              busy_out,
  output logic              done_out,
  output logic              illegal_out,
  // flags
  output logic              flag_c_out,
  output logic              flag_z_out,
  output logic              flag_s_out,
  output logic              flag_v_out,
  output logic              flag_d_out,
  output logic              flag_h_out
);
  typedef enum logic [2:0] {
    K_ADC     = 3'b000,
    K_ADD     = 3'b001,
    K_AND     = 3'b010,
    K_BAND    = 3'b011,
    K_BIT_CMP = 3'b100,
    K_NONE    = 3'b111
  } bal_kind_t;

  bal_pkg::bal_state_t state_q;
  bal_kind_t           kind;
  logic [3:0]          cyc_q;
  logic [3:0]          budget;
  logic [1:0]          len;
  logic [5:0]          flags_q;
  logic [5:0]          flags_d;
  logic [W-1:0]        res_d;
  logic                wr_d;
  logic [W:0]          sum;
  logic                hc;
  logic [W-1:0]        bit_res;
  logic                bit_zero;

  function automatic logic in_range(input logic [7:0] op, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (op >= lo) && (op <= hi);
  endfunction

  // decode kind, size and cycle budget
  always_comb begin
    kind   = K_NONE;
    budget = bal_pkg::CYC_LONG;
    len    = bal_pkg::LEN_LONG;
    if (in_range(opcode_in, bal_pkg::OP_ADC_RR, bal_pkg::OP_ADC_IM)) begin
      kind = K_ADC; // RQ1
    end else if (in_range(opcode_in, bal_pkg::OP_ADD_RR, bal_pkg::OP_ADD_IM)) begin
      kind = K_ADD; // RQ2
    end else if (in_range(opcode_in, bal_pkg::OP_AND_RR, bal_pkg::OP_AND_IM)) begin
      kind = K_AND; // RQ7
    end else if (opcode_in == bal_pkg::OP_BAND) begin
      kind = K_BAND;
    end else if (opcode_in == bal_pkg::OP_BIT_CMP) begin
      kind = K_BIT_CMP; // RQ13
    end
    if (opcode_in == bal_pkg::OP_ADC_RR || opcode_in == bal_pkg::OP_ADD_RR ||
        opcode_in == bal_pkg::OP_AND_RR) begin
      budget = bal_pkg::CYC_SHORT; // RQ9
      len    = bal_pkg::LEN_SHORT; // RQ9
    end else if (opcode_in == bal_pkg::OP_ADC_IR || opcode_in == bal_pkg::OP_ADD_IR ||
                 opcode_in == bal_pkg::OP_AND_IR) begin
      // indirect working form: 6 cycles, short byte count as encoded
      len    = bal_pkg::LEN_SHORT; // RQ9
    end
  end

  // adder: carry in only for adc
  assign sum = {1'b0, dst_in} + {1'b0, src_in} +
               {{W{1'b0}}, (kind == K_ADC) & flags_q[bal_pkg::F_C]}; // RQ1 RQ2
  assign hc  = dst_in[bal_pkg::NIB_MSB+1] ^ src_in[bal_pkg::NIB_MSB+1] ^
               sum[bal_pkg::NIB_MSB+1];

  bal_bitop u_bitop (
    .dst_in    (dst_in),
    .src_in    (src_in),
    .idx_in    (byte2_in[bal_pkg::BF_IDX_HI:bal_pkg::BF_IDX_LO]), // RQ11
    .dir_in    (byte2_in[bal_pkg::BF_DIR]),                        // RQ11
    .is_cmp_in (kind == K_BIT_CMP),
    .res_out   (bit_res),
    .zero_out  (bit_zero)
  );

  // result and flag selection
  always_comb begin
    flags_d = flags_q; // RQ15
    res_d   = dst_in;
    wr_d    = 1'b0;
    case (kind)
      K_ADC, K_ADD: begin
        res_d                 = sum[W-1:0];
        wr_d                  = 1'b1;
        flags_d[bal_pkg::F_C] = sum[W]; // RQ3
        flags_d[bal_pkg::F_V] = (dst_in[W-1] == src_in[W-1]) &&
                                (sum[W-1] != dst_in[W-1]); // RQ4
        flags_d[bal_pkg::F_Z] = (sum[W-1:0] == {W{1'b0}}); // RQ5
        flags_d[bal_pkg::F_S] = sum[W-1]; // RQ5
        flags_d[bal_pkg::F_H] = hc; // RQ6
        flags_d[bal_pkg::F_D] = 1'b0; // RQ6
      end
      K_AND: begin
        res_d                 = dst_in & src_in; // RQ7
        wr_d                  = 1'b1;
        flags_d[bal_pkg::F_Z] = ((dst_in & src_in) == {W{1'b0}}); // RQ8
        flags_d[bal_pkg::F_S] = dst_in[W-1] & src_in[W-1]; // RQ8
        flags_d[bal_pkg::F_V] = 1'b0; // RQ8
      end
      K_BAND: begin
        res_d                 = bit_res; // RQ10
        wr_d                  = 1'b1;
        flags_d[bal_pkg::F_Z] = bit_zero; // RQ12
        flags_d[bal_pkg::F_S] = 1'b0; // RQ12
      end
      K_BIT_CMP: begin
        flags_d[bal_pkg::F_Z] = bit_zero; // RQ13
        flags_d[bal_pkg::F_S] = 1'b0; // RQ13
      end
      default: begin
        flags_d = flags_q;
      end
    endcase
  end

  // sequencer: result lands at start, done after the cycle budget
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state_q <= bal_pkg::BAL_IDLE;
      cyc_q   <= 4'h0;
    end else if (clk_en_in) begin
      case (state_q)
        bal_pkg::BAL_IDLE: begin
          if (start_in && kind != K_NONE) begin
            state_q <= bal_pkg::BAL_BUSY;
            // accept edge and done cycle both count toward the budget
            cyc_q   <= budget - 4'h3; // RQ9 RQ14
          end
        end
        bal_pkg::BAL_BUSY: begin
          if (cyc_q == 4'h0) begin
            state_q <= bal_pkg::BAL_DONE;
          end else begin
            cyc_q <= cyc_q - 4'h1;
          end
        end
        default: begin
          state_q <= bal_pkg::BAL_IDLE;
        end
      endcase
    end
  end

  // flags and result capture
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      flags_q       <= bal_pkg::FLAGS_RST;
      result_out    <= {W{1'b0}};
      wr_dst_out    <= 1'b0;
      wreg_addr_out <= 4'h0;
      inst_len_out  <= 2'h0;
      illegal_out   <= 1'b0;
    end else if (clk_en_in) begin
      wr_dst_out <= 1'b0;
      if (state_q == bal_pkg::BAL_IDLE && start_in) begin
        illegal_out <= (kind == K_NONE);
        if (kind != K_NONE) begin
          flags_q       <= flags_d;
          result_out    <= res_d;
          wr_dst_out    <= wr_d; // RQ13
          wreg_addr_out <= byte2_in[bal_pkg::BF_REG_HI:bal_pkg::BF_REG_LO]; // RQ11
          inst_len_out  <= len; // RQ9 RQ14
        end
      end
    end
  end

  assign busy_out   = (state_q != bal_pkg::BAL_IDLE);
  assign done_out   = (state_q == bal_pkg::BAL_DONE);
  assign flag_c_out = flags_q[bal_pkg::F_C];
  assign flag_z_out = flags_q[bal_pkg::F_Z];
  assign flag_s_out = flags_q[bal_pkg::F_S];
  assign flag_v_out = flags_q[bal_pkg::F_V];
  assign flag_d_out = flags_q[bal_pkg::F_D];
  assign flag_h_out = flags_q[bal_pkg::F_H];
endmodule
`default_nettype wire

// *** test/bal_core_properties.sv ***
// Purpose: concurrent checks on bal_core ports
// Assumes: clk_en_in stays high while an op runs
// Notes:   helpers capture operands at the accepting edge
`timescale 1ns/1ps
`default_nettype none
module bal_core_properties (
  // watched ports
  input wire logic       sys_clk_in,
  input wire logic       rst_b_in,
  input wire logic       clk_en_in,
  input wire logic       start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] dst_in,
  input wire logic [7:0] src_in,
  input wire logic [7:0] result_out,
  input wire logic       wr_dst_out,
  input wire logic       busy_out,
  input wire logic       done_out,
  input wire logic       flag_c_out,
  input wire logic       flag_z_out,
  input wire logic       flag_s_out,
  input wire logic       flag_v_out,
  input wire logic       flag_d_out,
  input wire logic       flag_h_out
);
  logic       go, ar, cin, h_q, v_q;
  logic [8:0] sum_d, sum_q;
  assign go = start_in && clk_en_in && !busy_out && opcode_in inside
    {[8'h02:8'h06], [8'h12:8'h16], [8'h52:8'h56], 8'h67, 8'h17};
  assign ar = opcode_in[7:5] == 3'h0 && opcode_in[3:0] != 4'h7;
  // carry-in only for the adc family
  assign cin = opcode_in[4] & flag_c_out;
  assign sum_d = {1'h0, dst_in} + {1'h0, src_in} + {8'h00, cin};
  always_ff @(posedge sys_clk_in) begin
    sum_q <= sum_d;
    v_q   <= dst_in[7] == src_in[7] && sum_d[7] != dst_in[7];
    h_q   <= ({1'h0, dst_in[3:0]} + {1'h0, src_in[3:0]} + {4'h0, cin}) > 5'h0F;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_sum_result: assert property (go && ar |=> result_out == sum_q[7:0])
    else $error("add result wrong");
  a_add_carry: assert property (go && ar |=> flag_c_out == sum_q[8])
    else $error("add carry wrong");
  a_add_ovf: assert property (go && ar |=> flag_v_out == v_q)
    else $error("add overflow wrong");
  a_zero_sign: assert property (go && ar |=>
    flag_z_out == (sum_q[7:0] == 8'h00) && flag_s_out == sum_q[7]) else $error("add z/s wrong");
  a_half_dec: assert property (go && ar |=> flag_h_out == h_q && !flag_d_out)
    else $error("add h/d wrong");
  a_and_flags: assert property (go && opcode_in[7:4] == 4'h5 |=>
    result_out == ($past(dst_in) & $past(src_in)) && !flag_v_out && flag_s_out == result_out[7]
    && flag_z_out == (result_out == 8'h00) && $stable(flag_c_out) && $stable(flag_h_out)
    && $stable(flag_d_out)) else $error("and result or flags wrong");
  a_short_done: assert property (go && opcode_in[3:0] == 4'h2 |=>
    !done_out ##1 !done_out ##1 done_out ##1 !busy_out) else $error("short op timing wrong");
  a_long_done: assert property (go && opcode_in[3:0] != 4'h2 |=>
    !done_out [*4] ##1 done_out ##1 !busy_out) else $error("long op timing wrong");
  a_bit_flags: assert property (go && opcode_in[3:0] == 4'h7 |=>
    !flag_s_out && $stable(flag_c_out) && $stable(flag_v_out) && $stable(flag_h_out)
    && $stable(flag_d_out))
    else $error("bit op flags wrong");
  a_cmp_keep: assert property (go && opcode_in == 8'h17 |=>
    !wr_dst_out && result_out == $past(dst_in)) else $error("compare modified operand");
  c_bit_and: cover property (go && opcode_in == 8'h67);
  c_carry: cover property (go && ar ##1 flag_c_out);
  c_back: cover property (done_out ##1 go);
endmodule
bind bal_core bal_core_properties u_chk (.*);
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: directed bench for bal_core
// Assumes: clk_en_in high except in the refused-start scenario; ops back to back
// Notes:   flags compared as {c,z,s,v,d,h}; fl tracks the expected flags
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       sys_clk_in = 1'h0;
  logic       rst_b_in = 1'h0;
  logic       clk_en_in = 1'h1;
  logic       start_in = 1'h0;
  logic [7:0] opcode_in = 8'h00, byte2_in = 8'h00, dst_in = 8'h00, src_in = 8'h00;
  logic [7:0] result_out;
  logic [3:0] wreg_addr_out;
  logic [1:0] inst_len_out;
  logic       wr_dst_out, busy_out, done_out, illegal_out;
  logic       flag_c_out, flag_z_out, flag_s_out, flag_v_out, flag_d_out, flag_h_out;
  logic [5:0] fl = 6'h00;
  int         errors = 0, n_checks = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  bal_core DUT (.*);
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, b2, d, s, er, input logic [5:0] ef,
                     input logic ew, input logic [1:0] ln, input logic [3:0] cy);
    logic [3:0] n;
    opcode_in = op;
    byte2_in = b2;
    dst_in = d;
    src_in = s;
    start_in = 1'h1;
    @(negedge sys_clk_in);
    start_in = 1'h0;
    chk("result", er, result_out);
    chk("flags", {2'h0, ef}, {2'h0, flag_c_out, flag_z_out, flag_s_out, flag_v_out,
        flag_d_out, flag_h_out});
    chk("write", {7'h00, ew}, {7'h00, wr_dst_out});
    chk("busy", 8'h01, {7'h00, busy_out});
    chk("illegal", 8'h00, {7'h00, illegal_out});
    chk("length", {6'h00, ln}, {6'h00, inst_len_out});
    chk("address", {4'h0, b2[7:4]}, {4'h0, wreg_addr_out});
    n = 4'h1;
    while (done_out !== 1'h1) begin
      @(negedge sys_clk_in);
      n = n + 4'h1;
      if (n > 4'h9) begin
        errors++;
        $display("[ERR] done expected 1 seen %b", done_out);
        report_and_stop;
      end
    end
    chk("cycles", {4'h0, cy - 4'h1}, {4'h0, n});
    @(negedge sys_clk_in);
    chk("idle", 8'h00, {7'h00, busy_out});
  endtask
  task automatic arith_ops;
    logic [7:0]  dv [5] = '{8'h12, 8'h7F, 8'h08, 8'hFF, 8'h80};
    logic [7:0]  sv [5] = '{8'h03, 8'h01, 8'h08, 8'h01, 8'h80};
    logic [7:0]  s, r;
    logic [8:0]  w;
    logic        h;
    for (int f = 0; f < 3; f++) begin
      for (int k = 0; k < 5; k++) begin
        s = (f == 2) ? ~sv[k] : sv[k];
        w = {1'h0, dv[k]} + {1'h0, s} + {8'h00, f == 1 && fl[5]};
        h = ({1'h0, dv[k][3:0]} + {1'h0, s[3:0]} + {4'h0, f == 1 && fl[5]}) > 5'h0F;
        if (f == 2) begin
          r  = dv[k] & s;
          fl = {fl[5], r == 8'h00, r[7], 1'h0, fl[1:0]};
        end else begin
          r  = w[7:0];
          fl = {w[8], r == 8'h00, r[7], dv[k][7] == s[7] && r[7] != dv[k][7], 1'h0, h};
        end
        run({(f == 2) ? 4'h5 : 4'(f), 4'(k + 2)}, 8'h00, dv[k], s, r, fl, 1'h1,
            (k < 2) ? 2'h2 : 2'h3, (k == 0) ? 4'h4 : 4'h6);
      end
    end
  endtask
  task automatic refused_ops;
    opcode_in = 8'h07;
    start_in = 1'h1;
    @(negedge sys_clk_in);
    start_in = 1'h0;
    chk("illegal", 8'h01, {7'h00, illegal_out});
    chk("busy", 8'h00, {7'h00, busy_out});
    chk("write", 8'h00, {7'h00, wr_dst_out});
    chk("flags", {2'h0, fl}, {2'h0, flag_c_out, flag_z_out, flag_s_out, flag_v_out,
        flag_d_out, flag_h_out});
    // a legal start while frozen must leave the block idle and illegal set
    opcode_in = 8'h52;
    clk_en_in = 1'h0;
    start_in = 1'h1;
    @(negedge sys_clk_in);
    start_in = 1'h0;
    clk_en_in = 1'h1;
    chk("frozen", 8'h01, {busy_out, 6'h00, illegal_out});
    @(negedge sys_clk_in);
    chk("frozen idle", 8'h00, {7'h00, busy_out});
  endtask
  task automatic bit_ops;
    logic [31:0] t [5] = '{32'h67120705, 32'h67250507, 32'h672F80FE, 32'h17120701,
                           32'h17E20703};
    logic [7:0]  r;
    logic [2:0]  b;
    logic        x;
    foreach (t[i]) begin
      b = t[i][19:17];
      r = t[i][15:8];
      x = r[0] ~^ t[i][b];
      if (t[i][31:24] == 8'h67) begin
        x = t[i][16] ? r[b] & t[i][0] : r[0] & t[i][b];
        r[t[i][16] ? b : 3'h0] = x;
        x = ~x;
      end
      fl = {fl[5], x, 1'h0, fl[2:0]};
      run(t[i][31:24], t[i][23:16], t[i][15:8], t[i][7:0], r, fl, t[i][31:24] == 8'h67,
          2'h3, 4'h6);
    end
  endtask
  initial begin
    repeat (12) @(negedge sys_clk_in);
    chk("reset", 8'h00, {busy_out, flag_c_out, flag_z_out, flag_s_out, flag_v_out,
        flag_d_out, flag_h_out, wr_dst_out});
    rst_b_in = 1'h1;
    arith_ops();
    refused_ops();
    bit_ops();
    report_and_stop;
  end
endmodule
`default_nettype wire
